// ===== rtl/scwh_consts.svh
`ifndef SCWH_CONSTS_SVH
`define SCWH_CONSTS_SVH

// ==========================================
// control word codes
`define SCWH_CW_ENABLE 16'h0001
`define SCWH_CW_PAUSE 16'h0002
`define SCWH_CW_CONT 16'h0003
`define SCWH_CW_ESTOP 16'h0004
`define SCWH_CW_CSTOP 16'h0005
`define SCWH_CW_STEPDIR 16'h0006
`define SCWH_CW_DUAL 16'h0007

// ==========================================
// queued command word layout
`define SCWH_CMD_W 27
`define SCWH_STEPS_LSB 0
`define SCWH_STEPS_MSB 15
`define SCWH_SPEED_LSB 16
`define SCWH_SPEED_MSB 23
`define SCWH_DIR_BIT 24
`define SCWH_KIND_LSB 25
`define SCWH_KIND_MSB 26
`define SCWH_Q_DEPTH 4

// ==========================================
// timing
`define SCWH_CLK_NS 40
`define SCWH_PROC_MS 3
`define SCWH_PROC_CYC ((`SCWH_PROC_MS * 1000000) / `SCWH_CLK_NS)
`define SCWH_RAMP_US 100
`define SCWH_RAMP_CYC ((`SCWH_RAMP_US * 1000) / `SCWH_CLK_NS)

// ==========================================
// reset values
`define SCWH_RST_EN 1'b0
`define SCWH_RST_DUAL 1'b0

`endif

// ===== rtl/scwh_pkg.sv
package scwh_pkg;
  // ==========================================
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_DECEL = 3'h4
  } scwh_state_e;

  // ==========================================
  // move kinds
  typedef enum logic [1:0] {
    K_POS = 2'h0,
    K_DIST = 2'h1,
    K_VEL = 2'h2
  } scwh_kind_e;
endpackage

// ===== rtl/scwh_cmd_queue.sv
`timescale 1ns/1ps
`include "scwh_consts.svh"

module scwh_cmd_queue (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // fill side
  input wire logic push_i,
  input wire logic [`SCWH_CMD_W-1:0] push_data_i,
  // drain side
  input wire logic pop_i,
  input wire logic flush_i,
  output logic [`SCWH_CMD_W-1:0] head_o,
  output logic empty_o,
  output logic full_o
);
  logic [`SCWH_CMD_W-1:0] mem [0:`SCWH_Q_DEPTH-1];
  logic [1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [2:0] count, next_count;
  logic do_push, do_pop;

  // ==========================================
  // pointers; flush wins over push and pop so nothing survives a stop
  always_comb begin
    empty_o = (count == 3'h0);
    full_o = (count == 3'(`SCWH_Q_DEPTH));
    do_push = push_i && !full_o && !flush_i;
    do_pop = pop_i && !empty_o && !flush_i;
    next_wr_ptr = wr_ptr + 2'(do_push);
    next_rd_ptr = rd_ptr + 2'(do_pop);
    next_count = count + 3'(do_push) - 3'(do_pop);
    if (flush_i) begin
      next_wr_ptr = 2'h0;
      next_rd_ptr = 2'h0;
      next_count = 3'h0;
    end
    head_o = mem[rd_ptr];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rd_ptr <= 2'h0;
      wr_ptr <= 2'h0;
      count <= 3'h0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; entries are only read when counted valid
  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end
endmodule

// ===== rtl/scwh_pulse_gen.sv
`timescale 1ns/1ps

module scwh_pulse_gen (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // rate control
  input wire logic ramp_tick_i,
  input wire logic [7:0] target_i,
  input wire logic [7:0] acc_i,
  input wire logic halt_i,
  // pulse side
  output logic step_o,
  output logic [7:0] speed_o
);
  logic [15:0] phase, next_phase;
  logic [7:0] next_speed, amt;
  logic next_step;

  // ==========================================
  // ramp toward target, phase accumulator carry gives one step
  always_comb begin
    amt = (acc_i == 8'h00) ? 8'hFF : acc_i; // zero rate means jump
    next_speed = speed_o;
    if (ramp_tick_i && (speed_o < target_i)) begin
      next_speed = ((target_i - speed_o) > amt) ? speed_o + amt : target_i;
    end else if (ramp_tick_i && (speed_o > target_i)) begin
      next_speed = ((speed_o - target_i) > amt) ? speed_o - amt : target_i;
    end
    {next_step, next_phase} = {1'b0, phase} + {9'h000, speed_o};
    if (halt_i) begin
      next_speed = 8'h00;
      next_phase = 16'h0000;
      next_step = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      phase <= 16'h0000;
      speed_o <= 8'h00;
      step_o <= 1'b0;
    end else begin
      phase <= next_phase;
      speed_o <= next_speed;
      step_o <= next_step;
    end
  end
endmodule

// ===== rtl/scwh_stepper_ctl.sv
// Functional notes
// - commands enter the queue only after the enable-profile word
// - pause word stops further queued commands until continue
// - an active distance or position move finishes despite pause
// - continue clears pause, resumes, advances to next queued command
// - continue during a running command aborts it for the next one
// - velocity move persists through continue and empty queue until replaced or stopped
// - emergency stop halts pulses at once and empties the queue
// - controlled stop ramps to zero at present rate and empties queue
// - step/direction mode is default: pulses on step, level on direction
// - dual pulse mode: forward pulses on step, reverse pulses on direction
// - each control word is processed within 3 ms
// - with busy clear, status other than queue_empty_o and cmd_ready_o shows the last written word's effect
// - profile enable drops on estop, finished stop, illegal word; stops and flushes
`timescale 1ns/1ps
`include "scwh_consts.svh"

module scwh_stepper_ctl #(
  parameter int MAX_PROC_CYC = `SCWH_PROC_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // control word from the controller
  input wire logic ctl_wr_i,
  input wire logic [15:0] ctl_code_i,
  // profile command push
  input wire logic cmd_push_i,
  input wire logic [1:0] cmd_kind_i,
  input wire logic cmd_dir_i,
  input wire logic [7:0] cmd_speed_i,
  input wire logic [15:0] cmd_steps_i,
  input wire logic [7:0] acc_rate_i,
  // drive outputs
  output logic step_o,
  output logic dir_o,
  // status
  output logic profile_en_o,
  output logic paused_o,
  output logic ctl_busy_o,
  output logic illegal_o,
  output logic dual_mode_o,
  output logic moving_o,
  output logic queue_empty_o,
  output logic cmd_ready_o
);
  scwh_pkg::scwh_state_e state, next_state;
  scwh_pkg::scwh_kind_e cur_kind, next_kind;
  logic [15:0] left, next_left;
  logic [7:0] cur_speed, next_cur_speed;
  logic cur_dir, next_dir;
  logic en, next_en, paused, next_paused, dual, next_dual, illegal, next_illegal;
  logic pend_valid;
  logic [15:0] pend_code;
  logic q_push, q_pop, q_flush, q_empty, q_full;
  logic [`SCWH_CMD_W-1:0] q_head, push_word;
  logic [15:0] head_steps;
  logic halt, load, done, ctl_take;
  logic [7:0] target, gen_speed;
  logic step_evt, ramp_tick;
  logic [11:0] ramp_cnt, next_ramp_cnt;
  logic next_ramp_tick;
  logic next_step_o, next_dir_o;
  logic [31:0] busy_age;

  // ==========================================
  // submodules
  always_comb begin
    push_word = {cmd_kind_i, cmd_dir_i, cmd_speed_i, cmd_steps_i};
    q_push = cmd_push_i && en;
    head_steps = q_head[`SCWH_STEPS_MSB:`SCWH_STEPS_LSB];
  end

  scwh_cmd_queue u_queue (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .push_i(q_push),
    .push_data_i(push_word),
    .pop_i(q_pop),
    .flush_i(q_flush),
    .head_o(q_head),
    .empty_o(q_empty),
    .full_o(q_full)
  );

  scwh_pulse_gen u_pulse (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ramp_tick_i(ramp_tick),
    .target_i(target),
    .acc_i(acc_rate_i),
    .halt_i(halt),
    .step_o(step_evt),
    .speed_o(gen_speed)
  );

  // ==========================================
  // ramp divider, one-cycle enable
  always_comb begin
    next_ramp_tick = (ramp_cnt == 12'(`SCWH_RAMP_CYC - 1));
    next_ramp_cnt = next_ramp_tick ? 12'h000 : ramp_cnt + 12'h001;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ramp_cnt <= 12'h000;
      ramp_tick <= 1'b0;
    end else begin
      ramp_cnt <= next_ramp_cnt;
      ramp_tick <= next_ramp_tick;
    end
  end

  // ==========================================
  // control word capture; one cycle of work, far inside the 3 ms budget
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pend_valid <= 1'b0;
      pend_code <= 16'h0000;
    end else begin
      pend_valid <= ctl_wr_i;
      pend_code <= ctl_code_i;
    end
  end

  // ==========================================
  // sequencer: control words first, then queue execution
  always_comb begin
    next_state = state;
    next_kind = cur_kind;
    next_left = left;
    next_cur_speed = cur_speed;
    next_dir = cur_dir;
    next_en = en;
    next_paused = paused;
    next_dual = dual;
    next_illegal = illegal;
    q_pop = 1'b0;
    halt = 1'b0;
    load = 1'b0;
    ctl_take = 1'b0;
    done = (cur_kind != scwh_pkg::K_VEL) &&
      ((left == 16'h0000) || (step_evt && (left == 16'h0001)));
    if (pend_valid) begin
      next_illegal = 1'b0;
      case (pend_code)
        `SCWH_CW_ENABLE: next_en = 1'b1;
        `SCWH_CW_PAUSE: next_paused = 1'b1;
        `SCWH_CW_CONT: begin
          next_paused = 1'b0;
          if ((state == scwh_pkg::ST_RUN) && !q_empty && en) begin
            load = 1'b1;
            ctl_take = 1'b1;
          end
        end
        `SCWH_CW_ESTOP: begin
          next_en = 1'b0;
          ctl_take = 1'b1;
        end
        `SCWH_CW_CSTOP: begin
          if (state != scwh_pkg::ST_IDLE) begin
            next_state = scwh_pkg::ST_DECEL;
          end else begin
            next_en = 1'b0;
          end
          ctl_take = 1'b1;
        end
        `SCWH_CW_STEPDIR: next_dual = 1'b0;
        `SCWH_CW_DUAL: next_dual = 1'b1;
        default: begin
          next_illegal = 1'b1;
          next_en = 1'b0;
          ctl_take = 1'b1;
        end
      endcase
    end
    if (!ctl_take) begin
      case (state)
        scwh_pkg::ST_IDLE: begin
          load = en && !paused && !q_empty;
        end
        scwh_pkg::ST_RUN: begin
          if (step_evt && (left != 16'h0000)) begin
            next_left = left - 16'h0001;
          end
          if (cur_kind == scwh_pkg::K_VEL) begin
            load = !paused && !q_empty;
          end else if (done) begin
            load = !paused && !q_empty;
            if (paused || q_empty) begin
              next_state = scwh_pkg::ST_IDLE;
            end
          end
        end
        scwh_pkg::ST_DECEL: begin
          if (gen_speed == 8'h00) begin
            next_state = scwh_pkg::ST_IDLE;
            next_en = 1'b0;
          end
        end
        default: next_state = scwh_pkg::ST_IDLE;
      endcase
    end
    if (load) begin
      q_pop = 1'b1;
      next_state = scwh_pkg::ST_RUN;
      next_kind = scwh_pkg::scwh_kind_e'(q_head[`SCWH_KIND_MSB:`SCWH_KIND_LSB]);
      next_dir = q_head[`SCWH_DIR_BIT];
      next_cur_speed = q_head[`SCWH_SPEED_MSB:`SCWH_SPEED_LSB];
      next_left = head_steps;
    end
    // losing the profile kills pulses at once and drops the queue
    // an emergency stop or illegal word mid-ramp must not leave the ramp running
    if (!next_en) begin
      halt = 1'b1;
      next_state = scwh_pkg::ST_IDLE;
    end
    if (next_state == scwh_pkg::ST_IDLE) begin
      halt = 1'b1;
    end
    q_flush = !next_en || (next_state == scwh_pkg::ST_DECEL);
    target = (state == scwh_pkg::ST_RUN) ? cur_speed : 8'h00;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state <= scwh_pkg::ST_IDLE;
      cur_kind <= scwh_pkg::K_POS;
      left <= 16'h0000;
      cur_speed <= 8'h00;
      cur_dir <= 1'b0;
      en <= `SCWH_RST_EN;
      paused <= 1'b0;
      dual <= `SCWH_RST_DUAL;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      cur_kind <= next_kind;
      left <= next_left;
      cur_speed <= next_cur_speed;
      cur_dir <= next_dir;
      en <= next_en;
      paused <= next_paused;
      dual <= next_dual;
      illegal <= next_illegal;
    end
  end

  // ==========================================
  // pin mapping and status; all registered so the drive sees clean edges
  always_comb begin
    next_step_o = dual ? (step_evt && !cur_dir) : step_evt;
    next_dir_o = dual ? (step_evt && cur_dir) : cur_dir;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      step_o <= 1'b0;
      dir_o <= 1'b0;
      profile_en_o <= 1'b0;
      paused_o <= 1'b0;
      ctl_busy_o <= 1'b0;
      illegal_o <= 1'b0;
      dual_mode_o <= 1'b0;
      moving_o <= 1'b0;
      queue_empty_o <= 1'b1;
      cmd_ready_o <= 1'b0;
    end else begin
      step_o <= next_step_o;
      dir_o <= next_dir_o;
      profile_en_o <= next_en;
      paused_o <= next_paused;
      ctl_busy_o <= ctl_wr_i;
      illegal_o <= next_illegal;
      dual_mode_o <= next_dual;
      moving_o <= (next_state != scwh_pkg::ST_IDLE);
      queue_empty_o <= q_empty;
      cmd_ready_o <= next_en && !q_full; // one cycle stale; full pushes drop
    end
  end

  // ==========================================
  // checks
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !ctl_busy_o) begin
      busy_age <= 32'h0;
    end else begin
      busy_age <= busy_age + 32'h1;
    end
  end

  a_busy_bounded: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    busy_age < 32'(MAX_PROC_CYC))
    else $error("control word not processed in time");

  a_push_needs_en: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (cmd_push_i && !en && q_empty) |=> q_empty)
    else $error("command queued while profile disabled");

  a_pause_holds: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (paused && !pend_valid && state == scwh_pkg::ST_IDLE) |=> state == scwh_pkg::ST_IDLE)
    else $error("queue advanced while paused");

  a_pause_finish: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && pend_code == `SCWH_CW_PAUSE && state == scwh_pkg::ST_RUN &&
     cur_kind != scwh_pkg::K_VEL && left > 16'h0001) |=> state == scwh_pkg::ST_RUN)
    else $error("pause cut an active move");

  a_cont_clears: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && pend_code == `SCWH_CW_CONT) |=> (!paused && !paused_o))
    else $error("continue left pause set");

  a_cont_aborts: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && pend_code == `SCWH_CW_CONT && state == scwh_pkg::ST_RUN && en && !q_empty)
    |=> (state == scwh_pkg::ST_RUN && left == $past(head_steps)))
    else $error("continue did not start next command");

  a_vel_persists: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (state == scwh_pkg::ST_RUN && cur_kind == scwh_pkg::K_VEL && q_empty && !pend_valid)
    |=> state == scwh_pkg::ST_RUN)
    else $error("velocity move dropped");

  a_estop_halts: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && pend_code == `SCWH_CW_ESTOP)
    |=> (gen_speed == 8'h00 && q_empty && !step_evt && !en))
    else $error("emergency stop did not halt");

  a_cstop_ramps: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && pend_code == `SCWH_CW_CSTOP && state == scwh_pkg::ST_RUN)
    |=> (state == scwh_pkg::ST_DECEL && q_empty && target == 8'h00))
    else $error("controlled stop did not ramp");

  a_stepdir_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (step_evt && !dual) |=> (step_o && dir_o == $past(cur_dir)))
    else $error("step/direction mapping wrong");

  a_dual_map: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (step_evt && dual) |=> (step_o != dir_o))
    else $error("dual pulse mapping wrong");

  a_illegal_drop: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pend_valid && (pend_code == 16'h0000 || pend_code > `SCWH_CW_DUAL))
    |=> (illegal && !en && q_empty && state == scwh_pkg::ST_IDLE && dual == $past(dual)))
    else $error("illegal word not handled");
endmodule

// ===== test/scwh_drive_model.sv
`timescale 1ns/1ps

// ==========================================
// stepper drive model: tallies steps per direction
module scwh_drive_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // drive pins
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic dual_i,
  // step tallies
  output logic [15:0] fwd_o,
  output logic [15:0] rev_o
);
  logic [15:0] next_fwd;
  logic [15:0] next_rev;

  // mode follows the block's mode flag, so a wrong pin mapping shows as a wrong tally
  always_comb begin
    next_fwd = fwd_o;
    next_rev = rev_o;
    if (dual_i) begin
      next_fwd = fwd_o + 16'(step_i);
      next_rev = rev_o + 16'(dir_i);
    end else if (step_i) begin
      if (dir_i) begin
        next_rev = rev_o + 16'h0001;
      end else begin
        next_fwd = fwd_o + 16'h0001;
      end
    end
  end

  // tally registers
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fwd_o <= 16'h0000;
      rev_o <= 16'h0000;
    end else begin
      fwd_o <= next_fwd;
      rev_o <= next_rev;
    end
  end
endmodule

// ===== test/scwh_stepper_ctl_test.sv
`timescale 1ns/1ps
`include "scwh_consts.svh"

module scwh_stepper_ctl_test;
  // ==========================================
  // stimulus and observed signals
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ctl_wr_i = 1'b0;
  logic [15:0] ctl_code_i = 16'h0000;
  logic cmd_push_i = 1'b0;
  logic [1:0] cmd_kind_i = 2'h0;
  logic cmd_dir_i = 1'b0;
  logic [7:0] cmd_speed_i = 8'h00;
  logic [15:0] cmd_steps_i = 16'h0000;
  logic [7:0] acc_rate_i = 8'h00;
  logic step_o, dir_o, profile_en_o, paused_o, ctl_busy_o, illegal_o;
  logic dual_mode_o, moving_o, queue_empty_o, cmd_ready_o;
  logic [15:0] fwd, rev, f0, r0;
  int fails = 0;
  int checked = 0;

  scwh_stepper_ctl u_scwh_stepper_ctl (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .ctl_wr_i(ctl_wr_i), .ctl_code_i(ctl_code_i),
    .cmd_push_i(cmd_push_i), .cmd_kind_i(cmd_kind_i), .cmd_dir_i(cmd_dir_i),
    .cmd_speed_i(cmd_speed_i), .cmd_steps_i(cmd_steps_i), .acc_rate_i(acc_rate_i),
    .step_o(step_o), .dir_o(dir_o), .profile_en_o(profile_en_o),
    .paused_o(paused_o), .ctl_busy_o(ctl_busy_o), .illegal_o(illegal_o),
    .dual_mode_o(dual_mode_o), .moving_o(moving_o),
    .queue_empty_o(queue_empty_o), .cmd_ready_o(cmd_ready_o)
  );

  scwh_drive_model u_scwh_drive_model (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .step_i(step_o),
    .dir_i(dir_o), .dual_i(dual_mode_o), .fwd_o(fwd), .rev_o(rev)
  );

  // 25 MHz clock
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // ==========================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // one-cycle write, then busy must clear on the following edge
  task automatic cw(input logic [15:0] code);
    ctl_code_i = code;
    ctl_wr_i = 1'b1;
    tick(1);
    ctl_wr_i = 1'b0;
    chk(16'(ctl_busy_o), 16'h0001, "busy");
    tick(1);
    chk(16'(ctl_busy_o), 16'h0000, "done");
  endtask

  task automatic push(input logic [1:0] k, input logic d, input logic [15:0] n);
    cmd_kind_i = k;
    cmd_dir_i = d;
    cmd_speed_i = 8'hFF;
    cmd_steps_i = n;
    cmd_push_i = 1'b1;
    tick(1);
    cmd_push_i = 1'b0;
    // gap so a following push never re-raises the strobe in the same step
    tick(1);
  endtask

  // bounded wait for the sequencer to go idle
  task automatic idle();
    int n = 0;
    while (moving_o !== 1'b0 && n < 20000) begin
      tick(1);
      n++;
    end
    chk(16'(moving_o), 16'h0000, "stuck");
    // last step pulse is still one register away from the drive tally
    tick(2);
  endtask

  task automatic snap();
    f0 = fwd;
    r0 = rev;
  endtask

  // ==========================================
  // scenarios
  task automatic t_enable();
    chk(16'(dual_mode_o), 16'h0000, "default mode");
    push(scwh_pkg::K_DIST, 1'b0, 16'h0005);
    tick(3);
    chk(16'(queue_empty_o), 16'h0001, "push taken");
    chk(16'(moving_o), 16'h0000, "moved");
    chk(16'(cmd_ready_o), 16'h0000, "ready off");
    cw(`SCWH_CW_ENABLE);
    chk(16'(profile_en_o), 16'h0001, "enable");
    chk(16'(cmd_ready_o), 16'h0001, "ready on");
  endtask

  task automatic t_pause();
    snap();
    push(scwh_pkg::K_DIST, 1'b0, 16'h0005);
    push(scwh_pkg::K_DIST, 1'b0, 16'h0003);
    cw(`SCWH_CW_PAUSE);
    chk(16'(paused_o), 16'h0001, "pause");
    idle();
    chk(fwd - f0, 16'h0005, "move cut");
    tick(3000);
    chk(fwd - f0, 16'h0005, "ran paused");
    chk(16'(queue_empty_o), 16'h0000, "queue lost");
    cw(`SCWH_CW_CONT);
    chk(16'(paused_o), 16'h0000, "resume");
    tick(3);
    idle();
    chk(fwd - f0, 16'h0008, "next move");
  endtask

  task automatic t_abort();
    snap();
    push(scwh_pkg::K_DIST, 1'b0, 16'h03E8);
    push(scwh_pkg::K_DIST, 1'b1, 16'h0002);
    tick(4000);
    cw(`SCWH_CW_CONT);
    tick(3);
    idle();
    chk(16'(fwd - f0 < 16'h03E8), 16'h0001, "no abort");
    chk(rev - r0, 16'h0002, "next after abort");
  endtask

  // velocity survives continue, then ramps down on controlled stop
  task automatic t_vel_stop();
    push(scwh_pkg::K_VEL, 1'b0, 16'h0000);
    tick(4000);
    cw(`SCWH_CW_CONT);
    snap();
    tick(3000);
    chk(16'(moving_o), 16'h0001, "vel ended");
    chk(16'(fwd > f0), 16'h0001, "vel stalled");
    acc_rate_i = 8'h40;
    cw(`SCWH_CW_CSTOP);
    chk(16'(moving_o), 16'h0001, "no ramp");
    chk(16'(queue_empty_o), 16'h0001, "not flushed");
    idle();
    chk(16'(profile_en_o), 16'h0000, "still enabled");
    acc_rate_i = 8'h00;
  endtask

  task automatic t_modes();
    cw(`SCWH_CW_ENABLE);
    cw(`SCWH_CW_DUAL);
    chk(16'(dual_mode_o), 16'h0001, "dual");
    snap();
    push(scwh_pkg::K_DIST, 1'b0, 16'h0003);
    push(scwh_pkg::K_DIST, 1'b1, 16'h0002);
    tick(3);
    idle();
    tick(3);
    idle();
    chk(fwd - f0, 16'h0003, "dual fwd");
    chk(rev - r0, 16'h0002, "dual rev");
    cw(`SCWH_CW_STEPDIR);
    chk(16'(dual_mode_o), 16'h0000, "stepdir");
    snap();
    push(scwh_pkg::K_DIST, 1'b1, 16'h0002);
    tick(3);
    idle();
    chk(rev - r0, 16'h0002, "sd rev");
    chk(fwd - f0, 16'h0000, "sd fwd");
  endtask

  // queue a move behind a paused velocity run, then stop hard
  task automatic t_estop();
    acc_rate_i = 8'h40;
    push(scwh_pkg::K_VEL, 1'b0, 16'h0000);
    tick(3);
    cw(`SCWH_CW_PAUSE);
    push(scwh_pkg::K_DIST, 1'b0, 16'h0005);
    tick(4000);
    chk(16'(queue_empty_o), 16'h0000, "queue");
    cw(`SCWH_CW_ESTOP);
    // a pulse launched before the stop is still in the output register
    tick(2);
    snap();
    tick(3000);
    chk(fwd - f0, 16'h0000, "pulses");
    chk(16'(moving_o), 16'h0000, "moving");
    chk(16'(queue_empty_o), 16'h0001, "flush");
    chk(16'(profile_en_o), 16'h0000, "enabled");
    acc_rate_i = 8'h00;
  endtask

  task automatic t_illegal();
    logic [15:0] bad [2] = '{16'h0000, 16'h0008};
    cw(`SCWH_CW_DUAL);
    foreach (bad[i]) begin
      cw(`SCWH_CW_ENABLE);
      cw(bad[i]);
      chk(16'(illegal_o), 16'h0001, "flag");
      chk(16'(profile_en_o), 16'h0000, "enabled");
      chk(16'(dual_mode_o), 16'h0001, "mode");
    end
    cw(`SCWH_CW_ENABLE);
    chk(16'(illegal_o), 16'h0000, "flag held");
  endtask

  // ==========================================
  // closing and sequencing
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // run needs about 40k cycles; the margin covers slow ramps
  initial begin
    #(40 * 100000);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    resetn_i = 1'b1;
    t_enable();
    t_pause();
    t_abort();
    t_vel_stop();
    t_modes();
    t_estop();
    t_illegal();
    end_of_test();
  end
endmodule
